// ### design/pss_sequencer.sv
// start-up sequencer, fault latch, slice switch control and apb registers
`timescale 1ns/1ns
`include "pss_cfg.svh"

module pss_sequencer #(
	parameter int PEAKS = `PSS_PEAKS_OK,
	parameter int FAULT_TO_CYC = `PSS_FAULT_TO_CYC,
	parameter int SOFT_START_CYC = `PSS_SOFT_START_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog status inputs, asynchronous
	input wire logic supply_good,
	input wire logic enable_in,
	input wire logic ramp_start,
	input wire logic ramp_peak,
	input wire logic boost_fault,
	input wire logic gate_on_fault,
	input wire logic gate_off_fault,
	input wire logic input_fault,
	input wire logic thermal_trip,
	input wire logic slice_select,
	// analog controls and interrupt request
	output logic delay_cap_charge,
	output logic delay_cap_discharge,
	output logic ref_enable,
	output logic boost_enable,
	output logic boost_soft_start,
	output logic gate_off_enable,
	output logic gate_on_enable,
	output logic switch_pulldown,
	output logic switch_to_drain,
	output logic switch_to_source,
	output logic irq
);

	initial
	begin
		if (PEAKS < 6 || PEAKS > 15 || FAULT_TO_CYC < 1 || SOFT_START_CYC < 1)
			$error("pss_sequencer: unsupported parameter value");
	end

	localparam int NS = 10;

	// two-flop synchronisers, one per asynchronous input
	logic [NS-1:0] async_in;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	logic [NS-1:0] prev_q;
	assign async_in = {slice_select, thermal_trip, input_fault, gate_off_fault,
		gate_on_fault, boost_fault, ramp_peak, ramp_start, enable_in, supply_good};
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= async_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					prev_q[gi] <= sync2_q[gi];
				end
			end
		end
	endgenerate

	logic sup_s, en_s, therm_s, sel_s;
	logic start_p, peak_p, en_rise, sup_rise, sup_fall, en_fall;
	assign sup_s = sync2_q[0];
	assign en_s = sync2_q[1];
	assign therm_s = sync2_q[8];
	assign sel_s = sync2_q[9];
	assign start_p = sync2_q[2] & ~prev_q[2];
	assign peak_p = sync2_q[3] & ~prev_q[3];
	assign en_rise = en_s & ~prev_q[1];
	assign en_fall = ~en_s & prev_q[1];
	assign sup_rise = sup_s & ~prev_q[0];
	assign sup_fall = ~sup_s & prev_q[0];

	// sequencer state
	pss_pkg::pss_state_t state_q, state_d;
	logic [3:0] peaks_q, peaks_d;
	logic [3:0] ramps_q, ramps_d;
	logic ref_q, ref_d, boost_q, boost_d, goff_q, goff_d, gon_q, gon_d;
	logic dis_q, dis_d;
	logic [31:0] tmo_q, tmo_d;
	logic [31:0] ss_q, ss_d;
	logic fault_ev, therm_ev, tmo_ev, done_ev;
	logic chk_fault;

	// which comparators are armed depends on what is enabled so far
	always_comb
	begin
		chk_fault = sync2_q[7];
		if (boost_q && peak_p && ramps_q == 4'h3)
			chk_fault = chk_fault | sync2_q[4];
		if (ramps_q == 4'h6 && peak_p)
			chk_fault = chk_fault | sync2_q[5] | sync2_q[6];
	end

	always_comb
	begin
		state_d = state_q;
		peaks_d = peaks_q;
		ramps_d = ramps_q;
		ref_d = ref_q;
		boost_d = boost_q;
		goff_d = goff_q;
		gon_d = gon_q;
		dis_d = 1'b0;
		tmo_d = tmo_q;
		ss_d = (ss_q != 32'h0) ? ss_q - 32'h1 : 32'h0;
		fault_ev = 1'b0;
		therm_ev = 1'b0;
		tmo_ev = 1'b0;
		done_ev = 1'b0;
		unique case (state_q)
			pss_pkg::ST_WAIT_SUPPLY:
			begin
				if (sup_s && en_s)
				begin
					state_d = pss_pkg::ST_RAMPING;
					ramps_d = 4'h1;
					peaks_d = 4'h0;
					tmo_d = 32'h0;
				end
			end
			pss_pkg::ST_RAMPING:
			begin
				tmo_d = tmo_q + 32'h1;
				if (start_p)
				begin
					ramps_d = ramps_q + 4'h1;
					tmo_d = 32'h0;
					if (ramps_q + 4'h1 == 4'h3)
					begin
						boost_d = 1'b1;
						ss_d = 32'(SOFT_START_CYC);
					end
					if (ramps_q + 4'h1 == 4'h6)
						gon_d = 1'b1;
				end
				if (peak_p)
				begin
					peaks_d = peaks_q + 4'h1;
					dis_d = 1'b1;
					if (peaks_q == 4'h0)
						ref_d = 1'b1;
					if (peaks_q + 4'h1 == 4'h4)
						goff_d = 1'b1;
					if (peaks_q + 4'h1 == 4'(PEAKS))
					begin
						state_d = pss_pkg::ST_RUN;
						done_ev = 1'b1;
					end
				end
				if (tmo_q >= 32'(FAULT_TO_CYC) - 32'h1)
					tmo_ev = 1'b1;
				if (chk_fault || tmo_ev)
				begin
					fault_ev = 1'b1;
					dis_d = 1'b0;
					done_ev = 1'b0;
					state_d = pss_pkg::ST_LATCHED;
				end
			end
			pss_pkg::ST_RUN:
			begin
				if (sync2_q[7] || sync2_q[4] || sync2_q[5] || sync2_q[6])
				begin
					fault_ev = 1'b1;
					state_d = pss_pkg::ST_LATCHED;
				end
			end
			pss_pkg::ST_LATCHED:
			begin
				if (en_rise || sup_rise)
					state_d = pss_pkg::ST_WAIT_SUPPLY;
			end
		endcase
		if (therm_s && state_q != pss_pkg::ST_LATCHED)
		begin
			therm_ev = 1'b1;
			done_ev = 1'b0;
			state_d = pss_pkg::ST_LATCHED;
		end
		if (sup_fall || en_fall || !sup_s)
			state_d = pss_pkg::ST_WAIT_SUPPLY;
		if (state_d == pss_pkg::ST_WAIT_SUPPLY || state_d == pss_pkg::ST_LATCHED)
		begin
			ref_d = 1'b0;
			boost_d = 1'b0;
			goff_d = 1'b0;
			gon_d = 1'b0;
			ss_d = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= pss_pkg::ST_WAIT_SUPPLY;
			peaks_q <= 4'h0;
			ramps_q <= 4'h0;
			ref_q <= 1'b0;
			boost_q <= 1'b0;
			goff_q <= 1'b0;
			gon_q <= 1'b0;
			dis_q <= 1'b0;
			tmo_q <= 32'h0;
			ss_q <= 32'h0;
		end
		else
		begin
			state_q <= state_d;
			peaks_q <= peaks_d;
			ramps_q <= ramps_d;
			ref_q <= ref_d;
			boost_q <= boost_d;
			goff_q <= goff_d;
			gon_q <= gon_d;
			dis_q <= dis_d;
			tmo_q <= tmo_d;
			ss_q <= ss_d;
		end
	end

	// slice switch: break before make, one dead cycle on a change between drain and source
	logic [1:0] path_q, path_d;
	logic [1:0] want;
	always_comb
	begin
		if (state_q != pss_pkg::ST_RUN)
			want = 2'h0;
		else if (sel_s)
			want = 2'h2;
		else
			want = 2'h1;
		path_d = (path_q != 2'h0 && want != path_q) ? 2'h0 : want;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			path_q <= 2'h0;
		else
			path_q <= path_d;
	end

	assign delay_cap_charge = (state_q == pss_pkg::ST_RAMPING);
	assign delay_cap_discharge = dis_q;
	assign ref_enable = ref_q;
	assign boost_enable = boost_q;
	assign boost_soft_start = (ss_q != 32'h0);
	assign gate_off_enable = goff_q;
	assign gate_on_enable = gon_q;
	assign switch_pulldown = (path_q == 2'h0);
	assign switch_to_drain = (path_q == 2'h1);
	assign switch_to_source = (path_q == 2'h2);

	// apb registers
	logic [`PSS_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
	logic soft_en_q, soft_en_d;
	logic [31:0] rd_d, rd_q;
	logic wr, rd;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign ev = {tmo_ev, therm_ev, fault_ev, done_ev};
	always_comb
	begin
		ist_d = ist_q;
		imask_d = imask_q;
		soft_en_d = soft_en_q;
		if (wr && paddr == `PSS_ADDR_IRQ_STAT)
			ist_d = ist_q & ~pwdata[`PSS_IRQ_W-1:0];
		if (wr && paddr == `PSS_ADDR_IRQ_MASK)
			imask_d = pwdata[`PSS_IRQ_W-1:0];
		if (wr && paddr == `PSS_ADDR_CTRL)
			soft_en_d = pwdata[0];
		ist_d = ist_d | ev;
		rd_d = rd_q;
		if (rd)
		begin
			unique case (paddr)
				`PSS_ADDR_CTRL: rd_d = {31'h0, soft_en_q};
				`PSS_ADDR_STAT: rd_d = {20'h0, peaks_q, ramps_q, 1'b0, state_q};
				`PSS_ADDR_IRQ_STAT: rd_d = {28'h0, ist_q};
				`PSS_ADDR_IRQ_MASK: rd_d = {28'h0, imask_q};
				default: rd_d = 32'h0;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ist_q <= 4'h0;
			imask_q <= 4'h0;
			soft_en_q <= 1'b1;
			rd_q <= 32'h0;
		end
		else
		begin
			ist_q <= ist_d;
			imask_q <= imask_d;
			soft_en_q <= soft_en_d;
			rd_q <= rd_d;
		end
	end
	assign prdata = rd_q;
	assign pslverr = psel & penable & (paddr != `PSS_ADDR_CTRL) & (paddr != `PSS_ADDR_STAT)
		& (paddr != `PSS_ADDR_IRQ_STAT) & (paddr != `PSS_ADDR_IRQ_MASK);
	assign irq = |(ist_q & imask_q);

	// assertions
	a_one_hot_path: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot({switch_pulldown, switch_to_drain, switch_to_source}))
		else $error("switch paths not one-hot");
	a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
		switch_to_drain |=> !switch_to_source)
		else $error("switch went drain to source without break");
	a_pull_during: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == pss_pkg::ST_RAMPING) |-> switch_pulldown)
		else $error("switch not grounded during start-up");
	a_ref_peak1: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == pss_pkg::ST_RAMPING && peak_p && peaks_q == 4'h0 && !chk_fault
		&& !therm_s && sup_s && !en_fall && !tmo_ev) |=> ref_enable)
		else $error("reference not on after first peak");
	a_boost_late: assert property (@(posedge pclk) disable iff (!presetn)
		boost_enable |-> ramps_q >= 4'h3)
		else $error("boost enabled before ramp three");
	a_goff_peak4: assert property (@(posedge pclk) disable iff (!presetn)
		gate_off_enable |-> peaks_q >= 4'h4)
		else $error("gate-off on before fourth peak");
	a_gon_ramp6: assert property (@(posedge pclk) disable iff (!presetn)
		gate_on_enable |-> ramps_q >= 4'h6)
		else $error("gate-on on before ramp six");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == pss_pkg::ST_LATCHED && !en_rise && !sup_rise && sup_s && !en_fall)
		|=> state_q == pss_pkg::ST_LATCHED)
		else $error("fault latch released without enable or supply cycle");
	a_done_peaks: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == pss_pkg::ST_RUN) |-> peaks_q == 4'(PEAKS))
		else $error("run reached without full peak count");
	a_wait_supply: assert property (@(posedge pclk) disable iff (!presetn)
		!sup_s |=> !delay_cap_charge)
		else $error("delay cap charging without supply");
	a_therm: assert property (@(posedge pclk) disable iff (!presetn)
		therm_s |=> state_q != pss_pkg::ST_RUN && !boost_enable)
		else $error("thermal trip did not shut down");
	a_disch: assert property (@(posedge pclk) disable iff (!presetn)
		delay_cap_discharge |-> $past(peak_p))
		else $error("discharge without a peak");
	c_run: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == pss_pkg::ST_RUN);
	c_fault: cover property (@(posedge pclk) disable iff (!presetn)
		fault_ev);
	c_restart: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == pss_pkg::ST_LATCHED ##1 state_q == pss_pkg::ST_WAIT_SUPPLY);
	c_source: cover property (@(posedge pclk) disable iff (!presetn)
		switch_to_source);

endmodule // pss_sequencer

// ### include/pss_cfg.svh
// timing constants and counts for the panel supply start-up sequencer
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_PEAKS_OK 6
`define PSS_CLK_MHZ 100
`define PSS_SOFT_START_US 7000
`define PSS_FAULT_TO_US 23000
`define PSS_SOFT_START_CYC (`PSS_SOFT_START_US * `PSS_CLK_MHZ)
`define PSS_FAULT_TO_CYC (`PSS_FAULT_TO_US * `PSS_CLK_MHZ)
`define PSS_ADDR_CTRL 12'h000
`define PSS_ADDR_STAT 12'h004
`define PSS_ADDR_IRQ_STAT 12'h008
`define PSS_ADDR_IRQ_MASK 12'h00C
`define PSS_IRQ_W 4
`define PSS_IRQ_DONE 0
`define PSS_IRQ_FAULT 1
`define PSS_IRQ_THERM 2
`define PSS_IRQ_TMO 3
`endif

// ### include/pss_pkg.sv
// types for the panel supply start-up sequencer
package pss_pkg;
	typedef enum logic [2:0] {
		ST_WAIT_SUPPLY,
		ST_RAMPING,
		ST_RUN,
		ST_LATCHED
	} pss_state_t;
endpackage

// ### dv/pss_ramp_model.sv
// behavioural delay-cap ramp with its start and peak comparator levels
`timescale 1ns/1ns
module pss_ramp_model #(
	parameter int RAMP_CYC = 60
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// controls from the sequencer, and a stall from the bench
	input wire logic delay_cap_charge,
	input wire logic delay_cap_discharge,
	input wire logic stall,
	// comparator levels
	output logic ramp_start,
	output logic ramp_peak
);
	int cnt;
	logic seen;
	// stall freezes the node, as a leaky cap would, so no edge ever comes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 0;
			seen <= 1'h0;
			ramp_peak <= 1'h0;
			ramp_start <= 1'h0;
		end
		else if (!delay_cap_charge)
		begin
			// no charge current: the node sits discharged and both comparators stay low
			cnt <= 0;
			seen <= 1'h0;
			ramp_peak <= 1'h0;
			ramp_start <= 1'h0;
		end
		else
		begin
			cnt <= cnt + 1;
			if (delay_cap_discharge)
			begin
				cnt <= 0;
				seen <= 1'h1;
				ramp_peak <= 1'h0;
			end
			else if (cnt == RAMP_CYC && !stall)
				ramp_peak <= 1'h1;
			// first ramp starts with the charge itself, later ones after a discharge
			ramp_start <= seen && cnt >= 2 && cnt < 6 && !stall;
		end
	end
endmodule // pss_ramp_model

// ### dv/test_panel_supply_startup_sequencer.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/1ns
module test_panel_supply_startup_sequencer;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic supply_good, enable_in, slice_select, stall, ramp_start, ramp_peak;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] flt;
	logic [8:0] mon;
	logic [2:0] sw;
	logic delay_cap_charge, delay_cap_discharge, ref_enable, boost_enable, boost_soft_start;
	logic gate_off_enable, gate_on_enable, switch_pulldown, switch_to_drain, switch_to_source, irq;
	int n_errors = 0;
	int tests_run = 0;
	int k;
	typedef struct {logic [11:0] a; logic [31:0] d; logic e;} pss_row_t;
	pss_row_t rows [5] = '{'{12'h000, 32'h1, 1'h0}, '{12'h004, 32'h0, 1'h0},
		'{12'h008, 32'h0, 1'h0}, '{12'h00C, 32'h0, 1'h0}, '{12'h010, 32'h0, 1'h1}};
	assign mon = {switch_to_drain, delay_cap_charge, irq, boost_soft_start, switch_pulldown,
		gate_on_enable, gate_off_enable, boost_enable, ref_enable};
	assign sw = {switch_pulldown, switch_to_drain, switch_to_source};
	pss_sequencer #(.FAULT_TO_CYC(200), .SOFT_START_CYC(50)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_good(supply_good), .enable_in(enable_in), .ramp_start(ramp_start),
		.ramp_peak(ramp_peak), .boost_fault(flt[0]), .gate_on_fault(flt[1]),
		.gate_off_fault(flt[2]), .input_fault(flt[3]), .thermal_trip(flt[4]),
		.slice_select(slice_select), .delay_cap_charge(delay_cap_charge),
		.delay_cap_discharge(delay_cap_discharge), .ref_enable(ref_enable),
		.boost_enable(boost_enable), .boost_soft_start(boost_soft_start),
		.gate_off_enable(gate_off_enable), .gate_on_enable(gate_on_enable),
		.switch_pulldown(switch_pulldown), .switch_to_drain(switch_to_drain),
		.switch_to_source(switch_to_source), .irq(irq));
	pss_ramp_model #(.RAMP_CYC(60)) ramp (.pclk(pclk), .presetn(presetn),
		.delay_cap_charge(delay_cap_charge), .delay_cap_discharge(delay_cap_discharge),
		.stall(stall), .ramp_start(ramp_start), .ramp_peak(ramp_peak));
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task report_and_stop();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("ERROR %s exp %h seen %h", n, e, g);
			n_errors++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int j;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		j = 0;
		do
		begin
			@(posedge pclk);
			j++;
		end while (pready !== 1'h1 && j < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (j >= 50)
		begin
			chk("pready", 32'h1, 32'h0);
			report_and_stop();
		end
	endtask
	task wait_sig(input int i, input logic v, input int lim);
		k = 0;
		while (mon[i] !== v && k < lim)
		begin
			@(negedge pclk);
			k++;
		end
		chk("wait bit", {31'h0, v}, {31'h0, mon[i]});
		if (mon[i] !== v)
			report_and_stop();
	endtask
	task poll_state(input logic [2:0] s, input int lim);
		k = 0;
		do
		begin
			apb(1'h0, 12'h004, 32'h0, rd, er);
			k++;
		end while (rd[2:0] !== s && k < lim);
		chk("state", {29'h0, s}, {29'h0, rd[2:0]});
		if (rd[2:0] !== s)
			report_and_stop();
	endtask
	// overlap or gap of switch paths shows up at any settled point
	always @(negedge pclk)
	begin
		if (presetn === 1'h1 && !(sw === 3'h1 || sw === 3'h2 || sw === 3'h4))
		begin
			$display("ERROR switch paths exp one-hot seen %b", sw);
			n_errors++;
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, supply_good, stall, flt} = '0;
		enable_in = 1'h1;
		slice_select = 1'h1;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i])
		begin
			apb(1'h0, rows[i].a, 32'h0, rd, er);
			chk("read data", rows[i].d, rd);
			chk("slave error", {31'h0, rows[i].e}, {31'h0, er});
		end
		repeat (20) @(negedge pclk);
		chk("charge idle", 32'h0, {31'h0, delay_cap_charge});
		@(posedge pclk);
		supply_good <= 1'h1;
		wait_sig(7, 1'h1, 10);
		wait_sig(0, 1'h1, 200);
		chk("boost early", 32'h0, {31'h0, boost_enable});
		chk("pulldown", 32'h1, {31'h0, switch_pulldown});
		wait_sig(1, 1'h1, 300);
		chk("soft start", 32'h1, {31'h0, boost_soft_start});
		chk("off early", 32'h0, {31'h0, gate_off_enable});
		k = 0;
		while (boost_soft_start === 1'h1 && k < 100)
		begin
			@(negedge pclk);
			k++;
		end
		chk("soft length", 32'h1, {31'h0, k >= 49 && k <= 51});
		wait_sig(2, 1'h1, 300);
		chk("on early", 32'h0, {31'h0, gate_on_enable});
		wait_sig(3, 1'h1, 300);
		wait_sig(4, 1'h0, 300);
		apb(1'h0, 12'h004, 32'h0, rd, er);
		chk("status run", 32'h00000662, rd);
		chk("to source", 32'h1, {31'h0, switch_to_source});
		@(posedge pclk);
		slice_select <= 1'h0;
		wait_sig(8, 1'h1, 10);
		apb(1'h1, 12'h00C, 32'h1, rd, er);
		wait_sig(6, 1'h1, 3);
		apb(1'h1, 12'h00C, 32'h0, rd, er);
		wait_sig(6, 1'h0, 3);
		apb(1'h1, 12'h008, 32'h1, rd, er);
		apb(1'h0, 12'h008, 32'h0, rd, er);
		chk("cleared", 32'h0, rd);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'h1, 12'h008, 32'hF, rd, er);
			@(posedge pclk);
			flt <= 5'h01 << i;
			poll_state(3'h3, 300);
			if (i == 3)
				chk("no peak", 32'h0, {28'h0, rd[11:8]});
			chk("enables off", 32'h0, {29'h0, boost_enable, gate_on_enable, gate_off_enable});
			apb(1'h0, 12'h008, 32'h0, rd, er);
			chk("cause", 32'h1, {31'h0, rd[i == 4 ? 2 : 1]});
			@(posedge pclk);
			flt <= 5'h00;
			repeat (30) @(negedge pclk);
			poll_state(3'h3, 1);
			@(posedge pclk);
			if (i % 2)
				supply_good <= 1'h0;
			else
				enable_in <= 1'h0;
			@(posedge pclk);
			supply_good <= 1'h1;
			enable_in <= 1'h1;
			wait_sig(7, 1'h1, 20);
		end
		apb(1'h1, 12'h008, 32'hF, rd, er);
		@(posedge pclk);
		stall <= 1'h1;
		poll_state(3'h3, 200);
		apb(1'h1, 12'h00C, 32'h8, rd, er);
		wait_sig(6, 1'h1, 3);
		apb(1'h1, 12'h008, 32'h8, rd, er);
		wait_sig(6, 1'h0, 3);
		@(posedge pclk);
		stall <= 1'h0;
		presetn <= 1'h0;
		@(negedge pclk);
		chk("reset outputs", 32'h4, {29'h0, switch_pulldown, ref_enable, delay_cap_charge});
		@(posedge pclk);
		presetn <= 1'h1;
		report_and_stop();
	end
endmodule // test_panel_supply_startup_sequencer
